// ### verilog/cod_pkg.sv
// package for the card option and address decode block
// assumes one 10 MHz system clock and an 8-bit register port
package cod_pkg;
  localparam int REG_AW = 4;
  localparam int REG_DW = 8;
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_CLKSEL = 4'h1;
  localparam logic [3:0] OFS_ROUTE  = 4'h2;
  localparam logic [3:0] OFS_STAT   = 4'h3;
  localparam logic [3:0] OFS_MASK   = 4'h4;
  localparam logic [3:0] OFS_STATE  = 4'h5;
  // control register bits
  localparam int CTL_ECHO   = 0;
  localparam int CTL_FOURW  = 1;
  localparam int CTL_RTSCTL = 2;
  localparam int CTL_CTSFIT = 3;
  localparam int CTL_WINV   = 4;
  localparam int CTL_WDOFF  = 5;
  localparam logic [7:0] RST_CTRL   = 8'h0B;
  localparam logic [7:0] RST_CLKSEL = 8'h00;
  localparam logic [7:0] RST_ROUTE  = 8'hFF;
  localparam logic [3:0] RST_MASK   = 4'h0;
  localparam logic [3:0] RST_STAT   = 4'h0;
  // clock select and route field positions
  localparam int CS_W      = 3;
  localparam int CS0_LSB   = 0;
  localparam int CS1_LSB   = 4;
  localparam int RT_W      = 4;
  localparam int RT_TMP_LSB = 0;
  localparam int RT_SER_LSB = 4;
  // status bits
  localparam int ST_TEMP = 0;
  localparam int ST_WDOG = 1;
  localparam int ST_SER  = 2;
  localparam int ST_WDW  = 3;
  localparam int ST_N    = 4;
  // host interrupt lines 2..7 are indices 0..5, lines 10..14 are indices 6..10
  localparam int IRQ_LINES = 11;
  localparam int IRQ_WIDE  = 6;
  localparam int CLK_SRC_N = 5;
  localparam logic [2:0] WDW_SIZE = 3'h5;
  localparam int PIN_W = 38;
  // strobes idle high, everything else low
  localparam logic [37:0] PIN_RST = 38'h000C000000;
endpackage

// ### verilog/cod_top.sv
// card option selection and i/o address decode
// assumes isa pins and line-side pins are asynchronous to clk_sys_i;
// option bits live in registers reached over a plain register port
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module cod_top
  import cod_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic [REG_AW-1:0] reg_addr_i,
  input  wire logic [REG_DW-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [REG_DW-1:0] reg_rdata_o,
  input  wire logic [9:0]        isa_addr_i,
  input  wire logic              isa_ior_n_i,
  input  wire logic              isa_iow_n_i,
  input  wire logic              isa_aen_i,
  input  wire logic              bus16_i,
  input  wire logic [6:0]        sw_serial_on_i,
  input  wire logic [6:0]        sw_wdog_on_i,
  output logic                   serial_sel_o,
  output logic                   wdog_sel_o,
  output logic      [2:0]        reg_index_o,
  input  wire logic              uart_rts_i,
  input  wire logic              ext_cts_i,
  output logic                   line_rts_o,
  output logic                   uart_cts_o,
  output logic                   rx_enable_o,
  output logic                   tx_enable_o,
  input  wire logic              wdog_trip_i,
  output logic                   wdog_out_o,
  input  wire logic [4:0]        clk_src_i,
  output logic      [1:0]        ctr_clk_o,
  input  wire logic              temp_alarm_i,
  input  wire logic              serial_irq_i,
  output logic [IRQ_LINES-1:0]   isa_irq_o,
  output logic                   irq_o
);

  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] s1;
  logic [PIN_W-1:0] s2;
  logic [PIN_W-1:0] s3;
  logic [PIN_W-1:0] agree;
  logic [PIN_W-1:0] pin;
  logic [9:0]       p_addr;
  logic             p_ior_n;
  logic             p_iow_n;
  logic             p_aen;
  logic             p_bus16;
  logic [6:0]       p_sw_ser;
  logic [6:0]       p_sw_wd;
  logic             p_rts;
  logic             p_cts;
  logic             p_trip;
  logic             p_temp;
  logic             p_ser_irq;
  logic [4:0]       p_clk_src;
  logic [7:0]       ctrl;
  logic [7:0]       clksel;
  logic [7:0]       route;
  logic [ST_N-1:0]  mask;
  logic [ST_N-1:0]  status;
  logic [ST_N-1:0]  ev;
  logic [ST_N-1:0]  clr;
  logic             io_cyc;
  logic             next_serial_sel;
  logic             next_wdog_sel;
  logic             next_rts;
  logic             prev_temp;
  logic             prev_trip;
  logic [IRQ_LINES-1:0] next_irq;
  logic [1:0]           next_ctr_clk;
  logic [RT_W-1:0]      rt_tmp;
  logic [RT_W-1:0]      rt_ser;

  // three-stage synchroniser; a change counts once stages 2 and 3 agree
  assign raw = {isa_addr_i, isa_ior_n_i, isa_iow_n_i, isa_aen_i, bus16_i,
                sw_serial_on_i, sw_wdog_on_i, uart_rts_i, ext_cts_i,
                wdog_trip_i, temp_alarm_i, serial_irq_i, clk_src_i};
  assign agree = ~(s2 ^ s3);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1  <= PIN_RST;
      s2  <= PIN_RST;
      s3  <= PIN_RST;
      pin <= PIN_RST;
    end
    else
    begin
      s1  <= raw;
      s2  <= s1;
      s3  <= s2;
      pin <= (s2 & agree) | (pin & ~agree);
    end
  end

  assign {p_addr, p_ior_n, p_iow_n, p_aen, p_bus16, p_sw_ser, p_sw_wd,
          p_rts, p_cts, p_trip, p_temp, p_ser_irq, p_clk_src} = pin;

  // address decode; the switch reads active when on, so invert it
  assign io_cyc = (!p_ior_n || !p_iow_n) && !p_aen;
  assign next_serial_sel = io_cyc && (p_addr[9:3] == ~p_sw_ser);
  assign next_wdog_sel = io_cyc && (p_addr[9:3] == ~p_sw_wd)
                         && (p_addr[2:0] < WDW_SIZE);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      serial_sel_o <= 1'b0;
      wdog_sel_o   <= 1'b0;
      reg_index_o  <= 3'h0;
    end
    else
    begin
      serial_sel_o <= next_serial_sel;
      wdog_sel_o   <= next_wdog_sel;
      reg_index_o  <= p_addr[2:0];
    end
  end

  // line transceiver control
  assign next_rts = ctrl[CTL_RTSCTL] ? p_rts : 1'b1;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      line_rts_o  <= 1'b1;
      uart_cts_o  <= 1'b0;
      rx_enable_o <= 1'b0;
      tx_enable_o <= 1'b0;
    end
    else
    begin
      line_rts_o  <= next_rts;
      uart_cts_o  <= ctrl[CTL_CTSFIT] ? 1'b1 : p_cts;
      // echo keeps the receiver on so our own sends come back
      rx_enable_o <= ctrl[CTL_ECHO] ? 1'b1 : !next_rts;
      tx_enable_o <= ctrl[CTL_FOURW] ? 1'b1 : next_rts;
    end
  end

  // watchdog output; inverted polarity idles high
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wdog_out_o <= 1'b0;
    else
      wdog_out_o <= (p_trip && !ctrl[CTL_WDOFF]) ^ ctrl[CTL_WINV];
  end

  // counter clock source selection, one mux per counter
  for (genvar g = 0; g < 2; g++)
  begin : g_ctr
    logic [CS_W-1:0] sel;
    assign sel = clksel[(g == 0 ? CS0_LSB : CS1_LSB) +: CS_W];
    // codes beyond the five sources give a still clock
    assign next_ctr_clk[g] = (sel < 3'(CLK_SRC_N)) ? p_clk_src[sel] : 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctr_clk_o <= 2'h0;
    else
      ctr_clk_o <= next_ctr_clk;
  end

  // host interrupt routing; upper lines only exist on the wide bus
  assign rt_tmp = route[RT_TMP_LSB +: RT_W];
  assign rt_ser = route[RT_SER_LSB +: RT_W];

  for (genvar l = 0; l < IRQ_LINES; l++)
  begin : g_irq
    assign next_irq[l] = (l >= IRQ_WIDE && !p_bus16) ? 1'b0 :
                         ((rt_tmp == 4'(l)) && p_temp) ||
                         ((rt_ser == 4'(l)) && p_ser_irq);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      isa_irq_o <= '0;
    else
      isa_irq_o <= next_irq;
  end

  // register writes
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl   <= RST_CTRL;
      clksel <= RST_CLKSEL;
      route  <= RST_ROUTE;
      mask   <= RST_MASK;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        OFS_CTRL:   ctrl   <= reg_wdata_i;
        OFS_CLKSEL: clksel <= reg_wdata_i;
        OFS_ROUTE:  route  <= reg_wdata_i;
        OFS_MASK:   mask   <= reg_wdata_i[ST_N-1:0];
        default:    ;
      endcase
    end
  end

  // sticky event status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_temp <= 1'b0;
      prev_trip <= 1'b0;
    end
    else
    begin
      prev_temp <= p_temp;
      prev_trip <= p_trip;
    end
  end

  assign ev[ST_TEMP] = p_temp && !prev_temp;
  assign ev[ST_WDOG] = p_trip && !prev_trip;
  assign ev[ST_SER]  = next_serial_sel && !serial_sel_o;
  assign ev[ST_WDW]  = next_wdog_sel && !wdog_sel_o;
  assign clr = (reg_wr_i && reg_addr_i == OFS_STAT) ?
               reg_wdata_i[ST_N-1:0] : '0;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      status <= RST_STAT;
    else
      status <= (status & ~clr) | ev;
  end

  assign irq_o = |(status & mask);

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        OFS_CTRL:   reg_rdata_o <= ctrl;
        OFS_CLKSEL: reg_rdata_o <= clksel;
        OFS_ROUTE:  reg_rdata_o <= route;
        OFS_STAT:   reg_rdata_o <= {4'h0, status};
        OFS_MASK:   reg_rdata_o <= {4'h0, mask};
        OFS_STATE:  reg_rdata_o <= {p_bus16, wdog_out_o, uart_cts_o,
                                    line_rts_o, tx_enable_o, rx_enable_o,
                                    wdog_sel_o, serial_sel_o};
        default:    reg_rdata_o <= 8'h00;
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  a_echo_rx_on:
    assert property (ctrl[CTL_ECHO] |=> rx_enable_o)
    else $error("receiver off in echo mode");
  a_oneway_rx:
    assert property (!ctrl[CTL_ECHO] |=> rx_enable_o == !line_rts_o)
    else $error("one-way receiver not following rts");
  a_rts_source:
    assert property (1'b1 |=> line_rts_o ==
      ($past(ctrl[CTL_RTSCTL]) ? $past(p_rts) : 1'b1))
    else $error("rts line wrong source");
  a_cts_supply:
    assert property (ctrl[CTL_CTSFIT] |=> uart_cts_o)
    else $error("internal cts missing");
  a_two_wire_tx:
    assert property (!ctrl[CTL_FOURW] |=> tx_enable_o == line_rts_o)
    else $error("two-wire transmit not under rts");
  a_wdog_polarity:
    assert property (ctrl[CTL_WINV] && !p_trip |=> wdog_out_o)
    else $error("inverted watchdog not idling high");
  a_wdog_disable:
    assert property (ctrl[CTL_WDOFF] ##1 ctrl[CTL_WDOFF]
      |-> wdog_out_o == $past(ctrl[CTL_WINV]))
    else $error("disabled watchdog still drives");
  a_ctr0_clock:
    assert property (clksel[2:0] < 3'h5 |=>
      ctr_clk_o[0] == $past(p_clk_src[clksel[2:0]]))
    else $error("counter 0 clock wrong source");
  a_irq_narrow:
    assert property (!p_bus16 |=> isa_irq_o[IRQ_LINES-1:IRQ_WIDE] == '0)
    else $error("wide-bus irq line driven on narrow bus");
  a_wdog_window:
    assert property (wdog_sel_o |-> $past(p_addr[2:0]) < WDW_SIZE)
    else $error("watchdog window over five bytes");
  a_base_match:
    assert property ($rose(serial_sel_o) |->
      $past(p_addr[9:3]) == ~$past(p_sw_ser))
    else $error("serial select without base match");
  a_no_dma_sel:
    assert property (p_aen |=> !serial_sel_o && !wdog_sel_o)
    else $error("select during dma cycle");

  c_serial_access: cover property ($rose(serial_sel_o));
  c_wdog_access:   cover property ($rose(wdog_sel_o));
  c_irq_raised:    cover property ($rose(irq_o));
  c_half_duplex:   cover property (!ctrl[CTL_FOURW] && $fell(tx_enable_o));

endmodule

// ### tb/cod_far_model.sv
// far side model: connector and uart pins facing the card
// assumes one clock; pins change just after rising edges
`timescale 1ns/1ps
module cod_far_model
(
  input  wire logic       clk_i,
  input  wire logic       plug_i,
  input  wire logic       rts_i,
  output logic            uart_rts_o,
  output logic            ext_cts_o,
  output logic [4:0]      clk_src_o
);
  // mating plug ties cts high, pulled low when unplugged
  assign ext_cts_o = plug_i;
  // references held still so a selection reads as a level
  assign clk_src_o = 5'h16;
  always_ff @(posedge clk_i)
  begin
    uart_rts_o <= rts_i;
  end
endmodule

// ### tb/cod_top_tb.sv
// testbench for the option and decode block
// assumes cod_top and the far side model; 10 MHz clock
`timescale 1ns/1ps
module cod_top_tb
  import cod_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [7:0] wd = 8'h00, rdat, ctl;
  logic [9:0] ia = 10'h000;
  logic ior_n = 1'b1, iow_n = 1'b1, aen = 1'b0, b16 = 1'b0;
  logic [6:0] sws = 7'h24, sww = 7'h1F;
  logic ssel, wsel, rts_c = 1'b0, plug = 1'b1, urts, ects;
  logic lrts, ucts, rxe, txe, trip = 1'b0, wout, tmp = 1'b0;
  logic sirq = 1'b0, irq, er;
  logic [2:0] idx;
  logic [4:0] src;
  logic [1:0] cclk;
  logic [10:0] irqs;
  int errors = 0, cmp_count = 0;
  always #50 clk = ~clk;
  cod_far_model far_u (.clk_i(clk), .plug_i(plug), .rts_i(rts_c),
    .uart_rts_o(urts), .ext_cts_o(ects), .clk_src_o(src));
  cod_top dut_u (.clk_sys_i(clk), .rst_n_i(rst_n), .reg_addr_i(ra),
    .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_rdata_o(rdat), .isa_addr_i(ia), .isa_ior_n_i(ior_n),
    .isa_iow_n_i(iow_n), .isa_aen_i(aen), .bus16_i(b16),
    .sw_serial_on_i(sws), .sw_wdog_on_i(sww), .serial_sel_o(ssel),
    .wdog_sel_o(wsel), .reg_index_o(idx), .uart_rts_i(urts),
    .ext_cts_i(ects), .line_rts_o(lrts), .uart_cts_o(ucts),
    .rx_enable_o(rxe), .tx_enable_o(txe), .wdog_trip_i(trip),
    .wdog_out_o(wout), .clk_src_i(src), .ctr_clk_o(cclk),
    .temp_alarm_i(tmp), .serial_irq_i(sirq), .isa_irq_o(irqs),
    .irq_o(irq));
  task automatic chk(string n, logic [10:0] e, logic [10:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk("rdata", {3'h0, e}, {3'h0, rdat});
  endtask
  // pins cross a synchroniser: five edges, rts through the far model six
  task automatic st;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic dec(logic [9:0] a, logic [2:0] c, logic es, logic ew);
    @(posedge clk);
    ia <= a;
    {aen, ior_n, iow_n} <= c;
    st;
    chk("serial_sel", es, ssel);
    chk("wdog_sel", ew, wsel);
    chk("index", a[2:0], idx);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    chk("rts_reset", 11'h1, lrts);
    rst_n <= 1'b1;
    rd(OFS_CTRL, RST_CTRL);
    rd(OFS_CLKSEL, RST_CLKSEL);
    rd(OFS_ROUTE, RST_ROUTE);
    rd(OFS_MASK, {4'h0, RST_MASK});
    rd(OFS_STAT, {4'h0, RST_STAT});
    rd(4'hF, 8'h00);
    // serial base 2D8, watchdog base 300
    dec(10'h2DA, 3'b001, 1'b1, 1'b0);
    dec(10'h2DF, 3'b101, 1'b0, 1'b0);
    dec(10'h2DF, 3'b010, 1'b1, 1'b0);
    dec(10'h2E0, 3'b001, 1'b0, 1'b0);
    dec(10'h1DA, 3'b001, 1'b0, 1'b0);
    dec(10'h304, 3'b001, 1'b0, 1'b1);
    dec(10'h305, 3'b001, 1'b0, 1'b0);
    dec(10'h300, 3'b011, 1'b0, 1'b0);
    // serial and watchdog window accesses leave their sticky bits set
    rd(OFS_STAT, 8'h0C);
    rd(OFS_STATE, 8'h3C);
    for (int i = 0; i < 256; i++)
    begin
      ctl = {2'b00, i[5:0]};
      wr(OFS_CTRL, ctl);
      rts_c <= i[6];
      plug <= i[7];
      trip <= i[6] ^ i[7];
      st;
      er = ctl[CTL_RTSCTL] ? i[6] : 1'b1;
      chk("line_rts", er, lrts);
      chk("rx_en", ctl[CTL_ECHO] | !er, rxe);
      chk("tx_en", ctl[CTL_FOURW] | er, txe);
      chk("cts", ctl[CTL_CTSFIT] | i[7], ucts);
      chk("wdog", ((i[6] ^ i[7]) & !ctl[CTL_WDOFF]) ^ ctl[CTL_WINV],
        wout);
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(OFS_CLKSEL, {1'b0, 3'(7 - k), 1'b0, 3'(k)});
      st;
      chk("ctr0", (k < 5) ? src[k] : 1'b0, cclk[0]);
      chk("ctr1", (k > 2) ? src[7 - k] : 1'b0, cclk[1]);
    end
    // watchdog trips rose in the option sweep
    rd(OFS_STAT, 8'h0E);
    wr(OFS_STAT, 8'h0F);
    rd(OFS_STAT, 8'h00);
    @(posedge clk);
    tmp <= 1'b1;
    for (int l = 0; l < 12; l++)
    begin
      wr(OFS_ROUTE, {4'hF, 4'(l)});
      b16 <= l[0];
      st;
      chk("irq_route", (l < 6 || (l < 11 && l[0])) ? 11'h1 << l : 11'h0,
        irqs);
    end
    @(posedge clk);
    sirq <= 1'b1;
    wr(OFS_ROUTE, 8'h16);
    st;
    chk("irq_both", 11'h042, irqs);
    rd(OFS_STAT, 8'h01);
    chk("irq_masked", 11'h0, irq);
    wr(OFS_MASK, 8'h01);
    #1;
    chk("irq_on", 11'h1, irq);
    wr(OFS_STAT, 8'h01);
    rd(OFS_STAT, 8'h00);
    chk("irq_off", 11'h0, irq);
    final_report;
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    errors++;
    final_report;
  end
endmodule
